// [rtl/rpc_configurator.v]
`timescale 1ns/1ps
`include "rpc_consts.vh"

// Summary of operation
// - Table contents plus id and target parameters decide transmitted configuration packets
// - Walk table in order; four packet kinds
// - Wait for completion after each config request
// - Completion header mismatch means configuration failed
// - Configuration completion payload is never checked
// - No completion timeout; wait forever
// - Parameter adds optional receive register stage
// - Parameter gives populated table line count
// - Header word even, payload word odd
// - Parameter origin_id_param placed in every packet
// - Own stream while configuring, then hand it to the test master
// - Finished at end; failed too on error
// - Optional speed change to 5.0 first
// - Decode two-bit kind and its fields
// - Test master waits link up before start
// - Test master writes, reads back every window
// - Test fails on mismatch or configuration failure
// - Restart pulse reruns the whole test
module rpc_configurator #(
    parameter        EXTRA_PIPELINE  = 0,
    parameter        ROM_SIZE        = 8,
    parameter [15:0] origin_id_param = 16'h0000,
    parameter [1:0]  max_speed_param = 2'h2,
    parameter [7:0]  TGT_BUS         = 8'h01,
    parameter [4:0]  TGT_DEV         = 5'h00,
    parameter        NUM_BARS        = 1,
    parameter [31:0] BAR_BASE        = 32'h1000_0000
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        user_lnk_up,
    input  wire        speed_change_done,
    input  wire        pio_test_restart,
    output reg         speed_change_req_q,
    output reg  [63:0] tx_tdata_q,
    output reg         tx_tvalid_q,
    output reg         tx_tlast_q,
    input  wire        tx_tready,
    input  wire [63:0] rx_tdata,
    input  wire        rx_tvalid,
    input  wire        rx_tlast,
    output reg         finished_config_q,
    output reg         failed_config_q,
    output reg         pio_test_finished_q,
    output reg         pio_test_failed_q,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata_q,
    output reg         avs_waitrequest_q
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [2:0] C_IDLE  = 3'd0, C_SPEED = 3'd1, C_FETCH = 3'd2,
                     C_SEND  = 3'd3, C_TXW   = 3'd4, C_CPL   = 3'd5,
                     C_NEXT  = 3'd6, C_DONE  = 3'd7;
    localparam [2:0] P_LINK  = 3'd0, P_START = 3'd1, P_CFG   = 3'd2,
                     P_WR    = 3'd3, P_RD    = 3'd4, P_CPL   = 3'd5,
                     P_PASS  = 3'd6, P_FAIL  = 3'd7;

    // Configuration table, header at even index, payload at odd
    function [31:0] rom_word;
        input [9:0] idx;
        begin
            case (idx)
                10'd0:   rom_word = {2'h3, 3'h0, 1'b0, 10'd0, 12'h0, 4'hf};
                10'd1:   rom_word = 32'h0000_0000;
                10'd2:   rom_word = {2'h2, 3'h0, 1'b0, 10'd4, 12'h0, 4'hf};
                10'd3:   rom_word = BAR_BASE;
                10'd4:   rom_word = {2'h2, 3'h0, 1'b0, 10'd1, 12'h0, 4'h3};
                10'd5:   rom_word = 32'h0000_0007;
                10'd6:   rom_word = {2'h1, 3'h4, 19'h0, 8'h50};
                10'd7:   rom_word = 32'h0000_0000;
                default: rom_word = 32'h0000_0000;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [2:0]  cst_q;             // Configurator state
    reg  [9:0]  ptr_q;             // Table index of current header
    reg  [31:0] hdr_q;             // Current header word
    reg  [31:0] dat_q;             // Current payload word
    reg         own_q;             // Configurator owns the stream
    reg  [2:0]  pst_q;             // Test master state
    reg  [2:0]  bar_q;             // Window under test
    reg         pio_rd_q;          // Test packet is a read
    reg  [31:0] pattern_q;         // Write pattern base
    reg         restart_q;         // Restart request from software
    reg         tx_busy_q;         // Packet being issued
    reg  [1:0]  tx_beat_q;         // Next beat to issue
    reg         rx_sop_q;          // Next receive beat starts a packet
    reg  [1:0]  rx_idx_q;          // Receive beat index
    reg  [63:0] rx_h0_q;           // First completion beat
    reg         cpl_evt_q;         // Completion header seen
    reg         cpl_ok_q;          // Status, id and tag matched
    reg  [2:0]  cpl_fmt_q;         // Completion format
    reg  [31:0] cpl_data_q;        // Completion payload
    wire [63:0] r_data;            // Receive stream after optional stage
    wire        r_valid;
    wire        r_last;

    // ------------------------------------------------------------------
    // Optional receive stage
    // ------------------------------------------------------------------
    generate
        if (EXTRA_PIPELINE != 0) begin : g_rx_pipe
            reg  [63:0] pd_q;
            reg         pv_q;
            reg         pl_q;
            // One register on the receive path for timing
            always @(posedge clk) begin
                if (!reset_n) begin
                    pd_q <= 64'h0;
                    pv_q <= 1'b0;
                    pl_q <= 1'b0;
                end else begin
                    pd_q <= rx_tdata;
                    pv_q <= rx_tvalid;
                    pl_q <= rx_tlast;
                end
            end
            assign r_data  = pd_q;
            assign r_valid = pv_q;
            assign r_last  = pl_q;
        end else begin : g_rx_direct
            assign r_data  = rx_tdata;
            assign r_valid = rx_tvalid;
            assign r_last  = rx_tlast;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Packet field build
    // ------------------------------------------------------------------
    wire [1:0]  kind = hdr_q[`RPC_HDR_KIND_HI:`RPC_HDR_KIND_LO];
    wire [2:0]  func = hdr_q[`RPC_HDR_FUNC_HI:`RPC_HDR_FUNC_LO];
    wire [9:0]  regn = hdr_q[`RPC_HDR_REG_HI:`RPC_HDR_REG_LO];
    wire [7:0]  ctag = ptr_q[8:1];
    wire [7:0]  ptag = {5'h10, bar_q};
    wire        is_cfg = kind[1];
    wire [31:0] pio_addr = BAR_BASE + {13'h0, bar_q, 16'h0};
    wire [31:0] pio_val  = pattern_q ^ {29'h0, bar_q};
    reg  [31:0] dw0, dw1, dw2, dw3;
    reg  [1:0]  nbeats;

    // Header dwords for whichever source owns the stream
    always @* begin
        dw2 = 32'h0;
        dw3 = 32'h0;
        nbeats = 2'd2;
        if (own_q) begin
            if (is_cfg) begin
                // Type 0 configuration request
                dw0 = {(kind == `RPC_KIND_CFGWR) ? `RPC_FMT_3DW_DATA
                       : `RPC_FMT_3DW, `RPC_TYPE_CFG0, 14'h0, 10'd1};
                dw1 = {origin_id_param, ctag, 4'h0,
                       hdr_q[`RPC_HDR_BE_HI:0]};
                dw2 = {TGT_BUS, TGT_DEV, func, 4'h0, regn, 2'b00};
                dw3 = dat_q;
            end else begin
                // Message, with payload beat when it carries data
                dw0 = {(kind == `RPC_KIND_MSGD) ? `RPC_FMT_4DW_DATA
                       : `RPC_FMT_4DW, `RPC_TYPE_MSG,
                       hdr_q[`RPC_HDR_FUNC_HI:`RPC_HDR_FUNC_LO], 14'h0,
                       (kind == `RPC_KIND_MSGD) ? 10'd1 : 10'd0};
                dw1 = {origin_id_param, ctag,
                       hdr_q[`RPC_HDR_CODE_HI:0]};
                if (kind == `RPC_KIND_MSGD) begin
                    nbeats = 2'd3;
                end
            end
        end else begin
            // Single-dword memory write or read from the test master
            dw0 = {pio_rd_q ? `RPC_FMT_3DW : `RPC_FMT_3DW_DATA,
                   `RPC_TYPE_MEM, 14'h0, 10'd1};
            dw1 = {origin_id_param, ptag, 8'h0f};
            dw2 = pio_addr;
            dw3 = pio_val;
        end
    end

    // ------------------------------------------------------------------
    // Transmit engine
    // ------------------------------------------------------------------
    wire tx_go = (own_q && cst_q == C_SEND && !tx_busy_q) ||
                 (!own_q && (pst_q == P_WR || pst_q == P_RD) && !tx_busy_q);
    wire tx_adv = tx_busy_q && (!tx_tvalid_q || tx_tready);
    wire tx_end = tx_beat_q == nbeats - 2'd1;

    // Issue beats under back-pressure, holding data while not ready
    always @(posedge clk) begin
        if (!reset_n) begin
            tx_busy_q   <= 1'b0;
            tx_beat_q   <= 2'd0;
            tx_tdata_q  <= 64'h0;
            tx_tvalid_q <= 1'b0;
            tx_tlast_q  <= 1'b0;
        end else begin
            if (tx_tvalid_q && tx_tready) begin
                tx_tvalid_q <= 1'b0;
            end
            if (tx_go) begin
                tx_busy_q <= 1'b1;
                tx_beat_q <= 2'd0;
            end else if (tx_adv) begin
                case (tx_beat_q)
                    2'd0:    tx_tdata_q <= {dw1, dw0};
                    2'd1:    tx_tdata_q <= {dw3, dw2};
                    default: tx_tdata_q <= {32'h0, dat_q};
                endcase
                tx_tvalid_q <= 1'b1;
                tx_tlast_q  <= tx_end;
                tx_beat_q   <= tx_beat_q + 2'd1;
                if (tx_end) begin
                    tx_busy_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive completion decode
    // ------------------------------------------------------------------
    wire [7:0] want_tag = own_q ? ctag : ptag;

    // Never throttled; header fields only, payload just kept
    always @(posedge clk) begin
        if (!reset_n) begin
            rx_sop_q   <= 1'b1;
            rx_idx_q   <= 2'd0;
            rx_h0_q    <= 64'h0;
            cpl_evt_q  <= 1'b0;
            cpl_ok_q   <= 1'b0;
            cpl_fmt_q  <= 3'h0;
            cpl_data_q <= 32'h0;
        end else begin
            cpl_evt_q <= 1'b0;
            if (r_valid) begin
                rx_sop_q <= r_last;
                rx_idx_q <= rx_sop_q ? 2'd1 : rx_idx_q + 2'd1;
                if (rx_sop_q) begin
                    rx_h0_q <= r_data;
                end
                if (!rx_sop_q && rx_idx_q == 2'd1 &&
                    rx_h0_q[28:24] == `RPC_TYPE_CPL) begin
                    cpl_evt_q  <= 1'b1;
                    cpl_fmt_q  <= rx_h0_q[31:29];
                    cpl_ok_q   <= rx_h0_q[47:45] == `RPC_CPL_OK &&
                                  r_data[31:16] == origin_id_param &&
                                  r_data[15:8] == want_tag;
                    cpl_data_q <= r_data[63:32];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Configurator sequence
    // ------------------------------------------------------------------
    wire start_cfg = pst_q == P_START;
    wire [2:0] exp_fmt = (kind == `RPC_KIND_CFGRD) ? `RPC_FMT_3DW_DATA
                                                   : `RPC_FMT_3DW;

    // Speed change, table walk, completion wait and outcome flags
    always @(posedge clk) begin
        if (!reset_n) begin
            cst_q              <= C_IDLE;
            ptr_q              <= 10'd0;
            hdr_q              <= 32'h0;
            dat_q              <= 32'h0;
            own_q              <= 1'b1;
            speed_change_req_q <= 1'b0;
            finished_config_q  <= 1'b0;
            failed_config_q    <= 1'b0;
        end else if (start_cfg) begin
            // New start clears the held outcome
            own_q             <= 1'b1;
            ptr_q             <= 10'd0;
            finished_config_q <= 1'b0;
            failed_config_q   <= 1'b0;
            if (max_speed_param == `RPC_SPEED_5G) begin
                speed_change_req_q <= 1'b1;
                cst_q              <= C_SPEED;
            end else begin
                cst_q <= C_FETCH;
            end
        end else begin
            case (cst_q)
                C_IDLE: begin
                    cst_q <= C_IDLE;
                end
                C_SPEED: begin
                    // Attempt finishes either way before the table walk
                    if (speed_change_done) begin
                        speed_change_req_q <= 1'b0;
                        cst_q              <= C_FETCH;
                    end
                end
                C_FETCH: begin
                    hdr_q <= rom_word(ptr_q);
                    dat_q <= rom_word(ptr_q + 10'd1);
                    cst_q <= C_SEND;
                end
                C_SEND: begin
                    if (!tx_busy_q) begin
                        cst_q <= C_TXW;
                    end
                end
                C_TXW: begin
                    if (!tx_busy_q) begin
                        cst_q <= is_cfg ? C_CPL : C_NEXT;
                    end
                end
                C_CPL: begin
                    // No timeout: stays here until a completion
                    if (cpl_evt_q) begin
                        if (!cpl_ok_q || cpl_fmt_q != exp_fmt) begin
                            // Both flags and the hand-over in one edge
                            failed_config_q   <= 1'b1;
                            finished_config_q <= 1'b1;
                            own_q             <= 1'b0;
                            cst_q             <= C_IDLE;
                        end else begin
                            cst_q <= C_NEXT;
                        end
                    end
                end
                C_NEXT: begin
                    if (ptr_q + 10'd2 >= ROM_SIZE[9:0]) begin
                        cst_q <= C_DONE;
                    end else begin
                        ptr_q <= ptr_q + 10'd2;
                        cst_q <= C_FETCH;
                    end
                end
                C_DONE: begin
                    finished_config_q <= 1'b1;
                    own_q             <= 1'b0;
                    cst_q             <= C_IDLE;
                end
                default: cst_q <= C_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Test master sequence
    // ------------------------------------------------------------------
    wire cfg_end = finished_config_q && cst_q == C_IDLE;

    // Link wait, start pulse, window write and readback
    always @(posedge clk) begin
        if (!reset_n) begin
            pst_q               <= P_LINK;
            bar_q               <= 3'd0;
            pio_rd_q            <= 1'b0;
            pio_test_finished_q <= 1'b0;
            pio_test_failed_q   <= 1'b0;
        end else if (pio_test_restart || restart_q) begin
            pst_q               <= P_LINK;
            pio_test_finished_q <= 1'b0;
            pio_test_failed_q   <= 1'b0;
        end else begin
            case (pst_q)
                P_LINK: begin
                    if (user_lnk_up) begin
                        pst_q <= P_START;
                    end
                end
                P_START: begin
                    pst_q <= P_CFG;
                end
                P_CFG: begin
                    bar_q <= 3'd0;
                    if (cfg_end) begin
                        pst_q <= failed_config_q ? P_FAIL : P_WR;
                    end
                end
                P_WR: begin
                    if (!tx_busy_q) begin
                        pio_rd_q <= 1'b0;
                        pst_q    <= P_RD;
                    end
                end
                P_RD: begin
                    if (!tx_busy_q) begin
                        pio_rd_q <= 1'b1;
                        pst_q    <= P_CPL;
                    end
                end
                P_CPL: begin
                    if (cpl_evt_q) begin
                        if (!cpl_ok_q || cpl_data_q != pio_val) begin
                            pst_q <= P_FAIL;
                        end else if (bar_q == NUM_BARS - 1) begin
                            pst_q <= P_PASS;
                        end else begin
                            bar_q <= bar_q + 3'd1;
                            pst_q <= P_WR;
                        end
                    end
                end
                P_PASS: begin
                    pio_test_finished_q <= 1'b1;
                end
                P_FAIL: begin
                    pio_test_failed_q <= 1'b1;
                end
                default: pst_q <= P_LINK;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM register slave
    // ------------------------------------------------------------------
    wire av_take = (avs_read || avs_write) && avs_waitrequest_q;

    // Answer one cycle after the request; unmapped reads return zero
    always @(posedge clk) begin
        if (!reset_n) begin
            avs_waitrequest_q <= 1'b1;
            avs_readdata_q    <= 32'h0;
            pattern_q         <= `RPC_PATTERN_RESET;
            restart_q         <= 1'b0;
        end else begin
            restart_q         <= 1'b0;
            avs_waitrequest_q <= !av_take;
            // Write lands at the edge that sees waitrequest low
            if (avs_write && !avs_waitrequest_q) begin
                if (avs_address == `RPC_REG_CTRL) begin
                    restart_q <= avs_writedata[`RPC_CTRL_RESTART];
                end else if (avs_address == `RPC_REG_PATTERN) begin
                    pattern_q <= avs_writedata;
                end
            end
            if (av_take && avs_read) begin
                case (avs_address)
                    `RPC_REG_STATUS:  avs_readdata_q <= {22'h0, pst_q,
                        cst_q, pio_test_failed_q, pio_test_finished_q,
                        failed_config_q, finished_config_q};
                    `RPC_REG_PATTERN: avs_readdata_q <= pattern_q;
                    default:          avs_readdata_q <= 32'h0;
                endcase
            end
        end
    end

endmodule // rpc_configurator

// [rtl/rpc_consts.vh]
`ifndef RPC_CONSTS_VH
`define RPC_CONSTS_VH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define RPC_REG_CTRL        4'h0
`define RPC_REG_STATUS      4'h4
`define RPC_REG_PATTERN     4'h8
`define RPC_CTRL_RESTART    0
`define RPC_PATTERN_RESET   32'ha5a5_0000

// ----------------------------------------------------------------------
// Table header word layout
// ----------------------------------------------------------------------
`define RPC_HDR_KIND_HI     31
`define RPC_HDR_KIND_LO     30
`define RPC_HDR_FUNC_HI     29
`define RPC_HDR_FUNC_LO     27
`define RPC_HDR_REG_HI      25
`define RPC_HDR_REG_LO      16
`define RPC_HDR_CODE_HI     7
`define RPC_HDR_BE_HI       3
`define RPC_KIND_MSG        2'h0
`define RPC_KIND_MSGD       2'h1
`define RPC_KIND_CFGWR      2'h2
`define RPC_KIND_CFGRD      2'h3

// ----------------------------------------------------------------------
// Packet header encodings
// ----------------------------------------------------------------------
`define RPC_FMT_3DW         3'h0
`define RPC_FMT_3DW_DATA    3'h2
`define RPC_FMT_4DW         3'h1
`define RPC_FMT_4DW_DATA    3'h3
`define RPC_TYPE_MEM        5'h00
`define RPC_TYPE_CFG0       5'h04
`define RPC_TYPE_CPL        5'h0a
`define RPC_TYPE_MSG        2'h2
`define RPC_CPL_OK          3'h0
`define RPC_SPEED_5G        2'h2

`endif

// [sim/rpc_configurator_properties.sv]
`timescale 1ns/1ps
// Checks configurator outputs against their causes
module rpc_configurator_properties (
    input wire        clk, reset_n, user_lnk_up, pio_test_restart,
    input wire        tx_tready, tx_tvalid_q, tx_tlast_q,
    input wire        speed_change_req_q, finished_config_q,
    input wire        failed_config_q, pio_test_finished_q,
    input wire        pio_test_failed_q, avs_read, avs_write,
    input wire        avs_waitrequest_q,
    input wire [63:0] tx_tdata_q
);
    reg rs_q; // Set once a restart or register write happened
    always @(posedge clk) begin
        rs_q <= reset_n & (rs_q | pio_test_restart | avs_write);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_fail_with_done: assert property (failed_config_q |-> finished_config_q)
        else $error("failed flag without finished flag");
    a_tx_beat_held: assert property (tx_tvalid_q && !tx_tready |=>
        tx_tvalid_q && $stable(tx_tdata_q) && $stable(tx_tlast_q))
        else $error("stalled beat changed");
    a_flags_kept: assert property (finished_config_q && !rs_q
        && !pio_test_restart |=> finished_config_q) else $error("flag lost");
    a_no_tx_unlinked: assert property (!user_lnk_up |-> !tx_tvalid_q)
        else $error("transmit before link up");
    a_speed_then_tx: assert property (speed_change_req_q |-> !tx_tvalid_q)
        else $error("transmit during speed change");
    a_cfg_fail_told: assert property ($rose(failed_config_q)
        |-> ##[0:40] pio_test_failed_q) else $error("test fail not raised");
    a_pio_ok_cfg: assert property (pio_test_finished_q && !rs_q |->
        finished_config_q && !failed_config_q) else $error("test done early");
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest_q
        |=> !avs_waitrequest_q) else $error("bus answer late");
    a_answer_once: assert property (!avs_waitrequest_q |=> avs_waitrequest_q)
        else $error("bus answer too long");
    c_cfg_ok: cover property (finished_config_q && !failed_config_q);
    c_cfg_bad: cover property (failed_config_q);
    c_pio_ok: cover property (pio_test_finished_q);
endmodule // rpc_configurator_properties
bind rpc_configurator rpc_configurator_properties u_props (.*);

// [sim/rpc_core_model.sv]
`timescale 1ns/1ps
// Root port stream model: takes requests, answers with completions
module rpc_core_model #(parameter [15:0] ID = 16'h0) (
    input wire        clk, reset_n, bad, tx_tvalid_q, tx_tlast_q,
    input wire        speed_change_req_q,
    input wire [63:0] tx_tdata_q,
    output reg        user_lnk_up, speed_change_done, rx_tvalid, rx_tlast, err,
    output reg [63:0] rx_tdata,
    output wire       tx_tready,
    output reg [3:0]  ncfg, nmsg
);
    reg [63:0] b0_q;  // First beat of current packet
    reg [1:0]  beat_q;
    reg [31:0] mem_q; // Single word target memory
    reg [2:0]  st_q;  // Completion delay state
    reg [4:0]  cyc_q;
    wire [63:0] hd = (beat_q == 2'h0) ? tx_tdata_q : b0_q;
    wire cfg = hd[28:24] == 5'h04;
    wire mem = hd[28:24] == 5'h00;
    assign tx_tready = cyc_q[1:0] != 2'h3; // Stall every fourth cycle
    always @(posedge clk) begin
        if (!reset_n) begin
            {user_lnk_up, speed_change_done, rx_tvalid, rx_tlast, err} <= 5'h0;
            {b0_q, beat_q, st_q, cyc_q, ncfg, nmsg, rx_tdata} <= 0;
        end else begin
            cyc_q <= cyc_q + 5'h1;
            if (cyc_q == 5'h1f) user_lnk_up <= 1'b1;
            speed_change_done <= speed_change_req_q;
            {rx_tvalid, rx_tlast} <= 2'h0;
            rx_tdata <= ~rx_tdata; // Idle bus keeps toggling
            if (st_q != 3'h0) st_q <= st_q + 3'h1;
            if (tx_tvalid_q && st_q != 0 && b0_q[28:24] == 5'h04) err <= 1'b1;
            if (tx_tvalid_q && tx_tready) begin
                beat_q <= tx_tlast_q ? 2'h0 : beat_q + 2'h1;
                if (beat_q == 2'h0) b0_q <= tx_tdata_q;
                if (beat_q == 2'h1 && mem && hd[30]) mem_q <= tx_tdata_q[63:32];
                if (tx_tlast_q && (cfg || (mem && !hd[30]))) st_q <= 3'h1;
                if (tx_tlast_q && cfg) ncfg <= ncfg + 4'h1;
                if (tx_tlast_q && hd[28:27] == 2'h2) nmsg <= nmsg + 4'h1;
                if (tx_tlast_q && cfg && hd[63:48] != ID) err <= 1'b1;
            end
            if (st_q == 3'h4) begin // Header beat, status bad on request
                rx_tvalid <= 1'b1;
                rx_tdata <= {16'h0, bad ? 3'h4 : 3'h0, 13'h0,
                             b0_q[30] ? 3'h0 : 3'h2, 5'h0a, 24'h1};
            end
            if (st_q == 3'h5) begin // Tag beat with read data
                {rx_tvalid, rx_tlast, st_q} <= 5'h18;
                rx_tdata <= {mem_q, b0_q[63:40], 8'h0};
            end
        end
    end
endmodule // rpc_core_model

// [sim/test_rpc_configurator.sv]
`timescale 1ns/1ps
module test_rpc_configurator;
    reg clk = 0, reset_n = 0, bad = 0, pio_test_restart = 0;
    reg avs_read = 0, avs_write = 0;
    reg [3:0] avs_address = 0;
    reg [31:0] avs_writedata = 0, rd;
    wire user_lnk_up, speed_change_done, speed_change_req_q, tx_tready;
    wire tx_tvalid_q, tx_tlast_q, rx_tvalid, rx_tlast, err;
    wire finished_config_q, failed_config_q, pio_test_finished_q;
    wire pio_test_failed_q, avs_waitrequest_q;
    wire [63:0] tx_tdata_q, rx_tdata;
    wire [31:0] avs_readdata_q;
    wire [3:0] ncfg, nmsg;
    wire [3:0] flags = {finished_config_q, failed_config_q,
                        pio_test_finished_q, pio_test_failed_q};
    int fail_count = 0, checked = 0;
    rpc_configurator #(.origin_id_param(16'h0a5c)) uut (.*);
    rpc_core_model #(.ID(16'h0a5c)) u_core (.*);
    initial forever #5 clk = ~clk;
    task chk(input [31:0] g, e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task conclude;
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait: w=1 for pio finished low, else for a pio outcome
    task waitfor(input int w);
        int n;
        n = 0;
        while (w ? pio_test_finished_q !== 1'b0
                 : (pio_test_finished_q | pio_test_failed_q) !== 1'b1) begin
            @(negedge clk);
            if (++n > 5000) begin chk(0, 1); conclude; end
        end
    endtask
    // One register access, held until waitrequest is seen low
    task bus(input w, input [3:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
        @(posedge clk);
        while (avs_waitrequest_q !== 1'b0) begin
            if (++n > 20) begin chk(0, 1); conclude; end
            @(posedge clk);
        end
        rd = avs_readdata_q;
        {avs_write, avs_read} <= 2'h0;
    endtask
    task start_run(input b);
        @(posedge clk);
        {bad, reset_n} <= {b, 1'b0};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        waitfor(0);
    endtask
    task t_good;
        start_run(0);
        chk(ncfg, 3);
        chk(nmsg, 1);
        chk(err, 0);
        chk(flags, 4'ha);
        repeat (60) @(negedge clk);
        chk(flags, 4'ha);
    endtask
    task t_regs;
        bus(0, 4'h4, 0);
        chk(rd[3:0], 4'h5);
        bus(0, 4'h8, 0);
        chk(rd, 32'ha5a50000);
        bus(1, 4'h8, 32'h1234_5678);
        bus(0, 4'h8, 0);
        chk(rd, 32'h1234_5678);
        bus(1, 4'hc, 1);
        bus(0, 4'hc, 0);
        chk(rd, 0);
    endtask
    task t_restart;
        @(posedge clk) pio_test_restart <= 1'b1;
        @(posedge clk) pio_test_restart <= 1'b0;
        waitfor(1);
        waitfor(0);
        chk(pio_test_finished_q, 1);
    endtask
    task t_bad;
        start_run(1);
        chk(flags, 4'hd);
        chk(pio_test_failed_q, 1);
    endtask
    initial begin
        t_good;
        t_regs;
        t_restart;
        t_bad;
        conclude;
    end
endmodule // test_rpc_configurator
